/* File: design/emb_pkg.sv */
package emb_pkg;
  // ==========================================
  // Bus range select codes
  localparam logic [1:0] RANGE_EXT17 = 2'h0;
  localparam logic [1:0] RANGE_EXT16 = 2'h1;
  localparam logic [1:0] RANGE_LOW16_A = 2'h2;
  localparam logic [1:0] RANGE_LOW16_B = 2'h3;
  localparam int RANGE_POS = 1;
  // Page bit kept clear of the range field so both can be chosen freely
  localparam int PAGE_POS = 0;
  localparam logic [7:0] CFG_RESET = 8'hff;
  // ==========================================
  // Bus cycle timing, in clock cycles
  localparam logic [2:0] ALE_CYCLES = 3'h1;
  localparam logic [2:0] ADDR_CYCLES = 3'h2;
  localparam logic [2:0] DATA_CYCLES = 3'h3;
  localparam logic [17:0] ONCHIP_TOP_RESET = 18'h03fff;
  localparam logic [7:0] PORT_RESET = 8'hff;
  typedef enum logic [1:0] {EMB_IDLE, EMB_ALE, EMB_ADDR, EMB_DATA} emb_state_t;
endpackage : emb_pkg

/* File: design/emb_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Two-stage synchroniser for pin inputs
module emb_sync #(parameter int WIDTH = 1) (
  input wire logic i_clock,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  // No reset: a strap sampled at release must already have crossed both stages
  // First stage only feeds second stage
  always_ff @(posedge i_clock) begin
    meta_r <= i_async;
    o_sync <= meta_r;
  end
endmodule : emb_sync
`default_nettype wire

/* File: design/emb_bus.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - A17 on port 1 pin in 18-bit extended range only
// - A16 shares read strobe pin per range
// - Non-page: port 2 carries upper address
// - Non-page: port 0 muxes low address/data
// - ALE pulses at cycle start, address valid
// - Access input low: all code off-chip
// - Access input high: on-chip within range
// - Access input latched at reset only
// - Page mode: data rides on port 2
// - Port 0 open drain between cycles, no pullups
// - Strobes on every bus cycle, in all ranges
module emb_bus (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_first_config_byte,
  input wire logic [17:0] i_onchip_top,
  input wire logic i_external_access_select,
  input wire logic i_req,
  input wire logic i_req_code,
  input wire logic i_req_write,
  input wire logic [17:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_done,
  output logic o_onchip,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_gp0_out,
  input wire logic [7:0] i_gp2_out,
  input wire logic i_gp17_out,
  input wire logic i_gp37_out,
  input wire logic i_gp36_out,
  output logic [7:0] o_gp0_in,
  output logic [7:0] o_gp2_in,
  input wire logic [7:0] i_low_byte_port,
  output logic [7:0] o_low_byte_port,
  output logic [7:0] o_low_byte_port_oe,
  input wire logic [7:0] i_high_byte_port,
  output logic [7:0] o_high_byte_port,
  output logic [7:0] o_high_byte_port_oe,
  output logic o_address_bit_seventeen,
  output logic o_address_bit_sixteen,
  output logic o_write_strobe_n,
  output logic o_ale,
  output logic o_program_store_strobe_n
);
  // ==========================================
  // State
  typedef struct packed {
    emb_pkg::emb_state_t st;
    logic [2:0] cnt;
    logic ea;
    logic ea_taken;
    logic code;
    logic write;
    logic [17:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
  } emb_reg_t;
  emb_reg_t s_r;
  emb_reg_t s_nxt;
  logic [7:0] p0_s;
  logic [7:0] p2_s;
  logic ea_s;
  logic [1:0] range;
  logic page;
  logic ext17;
  logic ext16;
  logic go_onchip;

  // ==========================================
  // Down-counters of the address and data phases both end on the same tick
  function automatic logic last_tick(input logic [2:0] cnt);
    return cnt == 3'h1;
  endfunction : last_tick

  // ==========================================
  // Pin synchronisers
  // They run through reset, so the strap is settled in both stages at release
  emb_sync #(.WIDTH(17)) u_sync (
    .i_clock(i_clock),
    .i_async({i_external_access_select, i_high_byte_port, i_low_byte_port}),
    .o_sync({ea_s, p2_s, p0_s})
  );

  // ==========================================
  // Configuration decode
  // Page mode moves the data byte from port 0 over to port 2
  assign range = i_first_config_byte[emb_pkg::RANGE_POS +: 2];
  assign page = ~i_first_config_byte[emb_pkg::PAGE_POS];
  // Both extended ranges claim the read pin for address bit 16
  assign ext17 = (range == emb_pkg::RANGE_EXT17);
  assign ext16 = ext17 || (range == emb_pkg::RANGE_EXT16);
  // Code fetch goes on-chip only when strap high and in range
  assign go_onchip = i_req_code && s_r.ea && (i_req_addr <= i_onchip_top);
  // Ready waits for the strap, so no fetch is steered before its source is known
  assign o_req_ready = (s_r.st == emb_pkg::EMB_IDLE) && s_r.ea_taken;
  assign o_done = s_r.done;
  assign o_rdata = s_r.rdata;
  // On-chip code fetches are answered here and never start a bus cycle
  assign o_onchip = o_req_ready && i_req && go_onchip;
  assign o_gp0_in = p0_s;
  assign o_gp2_in = p2_s;

  // ==========================================
  // Bus cycle sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    // Strap captured once on the first cycle after reset release
    // Later changes on the strap pin are ignored until the next reset
    if (!s_r.ea_taken) begin
      s_nxt.ea = ea_s;
      s_nxt.ea_taken = 1'b1;
    end
    unique case (s_r.st)
      emb_pkg::EMB_IDLE: begin
        // A refused or on-chip request leaves the state untouched
        if (o_req_ready && i_req && !go_onchip) begin
          s_nxt.st = emb_pkg::EMB_ALE;
          s_nxt.cnt = emb_pkg::ALE_CYCLES;
          s_nxt.code = i_req_code;
          // Code fetches are never writes
          s_nxt.write = i_req_write && !i_req_code;
          s_nxt.addr = i_req_addr;
          s_nxt.wdata = i_req_wdata;
        end
      end
      emb_pkg::EMB_ALE: begin
        // The address stays on the pins from this tick to the data phase
        s_nxt.st = emb_pkg::EMB_ADDR;
        s_nxt.cnt = emb_pkg::ADDR_CYCLES;
      end
      emb_pkg::EMB_ADDR: begin
        s_nxt.cnt = s_r.cnt - 3'h1;
        if (last_tick(s_r.cnt)) begin
          s_nxt.st = emb_pkg::EMB_DATA;
          s_nxt.cnt = emb_pkg::DATA_CYCLES;
        end
      end
      emb_pkg::EMB_DATA: begin
        s_nxt.cnt = s_r.cnt - 3'h1;
        if (last_tick(s_r.cnt)) begin
          // Sample read data on the last strobe cycle
          // The pin path is two flops late, so the memory must answer early in the phase
          s_nxt.rdata = page ? p2_s : p0_s;
          s_nxt.st = emb_pkg::EMB_IDLE;
          s_nxt.done = 1'b1;
        end
      end
    endcase
  end

  // Synchronous reset parks the sequencer idle with the strap not yet taken
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // Pin multiplexing
  always_comb begin
    logic busy;
    logic in_data;
    logic strobe;
    busy = 1'b0;
    in_data = 1'b0;
    strobe = 1'b0;
    // Busy, data phase and strobe are decoded from registered state only
    busy = (s_r.st != emb_pkg::EMB_IDLE);
    in_data = (s_r.st == emb_pkg::EMB_DATA);
    strobe = in_data && !s_r.write;
    // Port 0 open drain: only low bits are driven, never high
    o_low_byte_port = 8'h00;
    o_low_byte_port_oe = ~i_gp0_out;
    o_high_byte_port = i_gp2_out;
    o_high_byte_port_oe = 8'hff;
    if (busy) begin
      // Bus cycles drive port 0 push-pull like address/data
      if (page) begin
        o_low_byte_port = s_r.addr[7:0];
        o_low_byte_port_oe = 8'hff;
        // Port 2 turns around for data; port 0 keeps the low address all cycle
        o_high_byte_port = in_data ? s_r.wdata : s_r.addr[15:8];
        o_high_byte_port_oe = (in_data && !s_r.write) ? 8'h00 : 8'hff;
      end else begin
        o_low_byte_port = in_data ? s_r.wdata : s_r.addr[7:0];
        o_low_byte_port_oe = (in_data && !s_r.write) ? 8'h00 : 8'hff;
        o_high_byte_port = s_r.addr[15:8];
      end
    end
    // ALE high only in the first state, address already placed
    o_ale = (s_r.st == emb_pkg::EMB_ALE);
    o_program_store_strobe_n = ~(strobe && s_r.code);
    // The write strobe pin is claimed for every bus cycle; between cycles it is
    // a port bit unless an extended range reserves it
    if (ext16 || busy) begin
      o_write_strobe_n = ~(in_data && s_r.write);
    end else begin
      o_write_strobe_n = i_gp36_out;
    end
    // In extended mode the read pin carries A16, read strobe moves to the store strobe
    if (ext16) begin
      o_address_bit_sixteen = busy ? s_r.addr[16] : 1'b1;
      o_program_store_strobe_n = ~strobe;
    end else begin
      o_address_bit_sixteen = strobe && !s_r.code ? 1'b0 : i_gp37_out;
    end
    // Address bit 17 only in the widest range; the pin parks high between cycles
    if (ext17) begin
      o_address_bit_seventeen = busy ? s_r.addr[17] : 1'b1;
    end else begin
      o_address_bit_seventeen = i_gp17_out;
    end
  end
endmodule : emb_bus
`default_nettype wire

/* File: sim/emb_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus pin checks
module emb_props (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [7:0] i_first_config_byte,
  input wire logic i_req,
  input wire logic i_req_code,
  input wire logic i_req_write,
  input wire logic [17:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  input wire logic o_req_ready,
  input wire logic o_onchip,
  input wire logic o_done,
  input wire logic [7:0] o_low_byte_port,
  input wire logic [7:0] o_high_byte_port,
  input wire logic o_address_bit_seventeen,
  input wire logic o_address_bit_sixteen,
  input wire logic o_ale,
  input wire logic o_program_store_strobe_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic tk;
  logic pg;
  logic x16;
  // Launch edge; page mode moves data off the low port
  assign tk = i_req && o_req_ready && !o_onchip;
  assign pg = !i_first_config_byte[emb_pkg::PAGE_POS];
  // Both extended ranges put address bit 16 on the read pin
  assign x16 = i_first_config_byte[emb_pkg::RANGE_POS +: 2] <= emb_pkg::RANGE_EXT16;
  sequence s_cyc; o_ale ##1 !o_ale [*5] ##1 o_done; endsequence
  property p_cyc; tk |=> s_cyc; endproperty
  a_cyc: assert property (p_cyc) else $error("cyc");
  property p_lo; o_ale |-> o_low_byte_port == $past(i_req_addr[7:0]); endproperty
  a_lo: assert property (p_lo) else $error("lo");
  property p_hi; o_ale |-> o_high_byte_port == $past(i_req_addr[15:8]); endproperty
  a_hi: assert property (p_hi) else $error("hi");
  property p_pw; tk && i_req_write && pg |-> ##4 o_high_byte_port == $past(i_req_wdata, 4); endproperty
  a_pw: assert property (p_pw) else $error("pw");
  property p_a17; o_ale && i_first_config_byte[emb_pkg::RANGE_POS +: 2] == emb_pkg::RANGE_EXT17
    |-> o_address_bit_seventeen == $past(i_req_addr[17]); endproperty
  a_a17: assert property (p_a17) else $error("a17");
  property p_a16; o_ale && x16 |-> o_address_bit_sixteen == $past(i_req_addr[16]); endproperty
  a_a16: assert property (p_a16) else $error("a16");
  property p_ps; tk && i_req_code |-> ##4 !o_program_store_strobe_n [*3]; endproperty
  a_ps: assert property (p_ps) else $error("ps");
  property p_od; o_req_ready |-> o_low_byte_port == 8'h00; endproperty
  a_od: assert property (p_od) else $error("od");
endmodule : emb_props
bind emb_bus emb_props u_props (
  .i_clock(i_clock),
  .i_reset_n(i_reset_n),
  .i_first_config_byte(i_first_config_byte),
  .i_req(i_req),
  .i_req_code(i_req_code),
  .i_req_write(i_req_write),
  .i_req_addr(i_req_addr),
  .i_req_wdata(i_req_wdata),
  .o_req_ready(o_req_ready),
  .o_onchip(o_onchip),
  .o_done(o_done),
  .o_low_byte_port(o_low_byte_port),
  .o_high_byte_port(o_high_byte_port),
  .o_address_bit_seventeen(o_address_bit_seventeen),
  .o_address_bit_sixteen(o_address_bit_sixteen),
  .o_ale(o_ale),
  .o_program_store_strobe_n(o_program_store_strobe_n)
);
`default_nettype wire

/* File: sim/emb_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Memory behind an address latch
module emb_mem (
  input wire logic i_clock,
  input wire logic i_ale,
  input wire logic i_rd,
  input wire logic i_pg,
  input wire logic [7:0] i_lo,
  input wire logic [7:0] i_lo_oe,
  input wire logic [7:0] i_hi,
  input wire logic [7:0] i_hi_oe,
  output logic [7:0] o_lo,
  output logic [7:0] o_hi
);
  logic [7:0] lat_r;
  // Latch holds once ALE falls
  always_ff @(posedge i_clock) begin
    if (i_ale) begin
      lat_r <= i_lo;
    end
  end
  // Port 0 has no pullup, so a floating bit reads inverted rather than held
  assign o_lo = (i_lo_oe & i_lo) | (~i_lo_oe & (i_rd && !i_pg ? lat_r ^ 8'h5a : ~lat_r));
  assign o_hi = (i_hi_oe & i_hi) | (~i_hi_oe & (i_rd && i_pg ? lat_r ^ 8'h5a : 8'hff));
endmodule : emb_mem
`default_nettype wire

/* File: sim/external_memory_bus_pins_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench
module external_memory_bus_pins_test;
  logic i_clock, i_reset_n, i_external_access_select, i_req, i_req_code, i_req_write, i_gp17_out, i_gp37_out;
  logic [7:0] i_first_config_byte, i_req_wdata, i_gp0_out, i_gp2_out, i_low_byte_port, i_high_byte_port, o_rdata;
  logic [17:0] i_onchip_top, i_req_addr;
  logic i_gp36_out, o_req_ready, o_done, o_onchip, o_address_bit_seventeen, o_address_bit_sixteen, o_write_strobe_n;
  logic o_ale, o_program_store_strobe_n;
  logic [7:0] o_gp0_in, o_gp2_in, o_low_byte_port, o_low_byte_port_oe, o_high_byte_port, o_high_byte_port_oe;
  int failures;
  int samples_checked;
  emb_bus uut (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_first_config_byte(i_first_config_byte),
    .i_onchip_top(i_onchip_top),
    .i_external_access_select(i_external_access_select),
    .i_req(i_req),
    .i_req_code(i_req_code),
    .i_req_write(i_req_write),
    .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata),
    .o_req_ready(o_req_ready),
    .o_done(o_done),
    .o_onchip(o_onchip),
    .o_rdata(o_rdata),
    .i_gp0_out(i_gp0_out),
    .i_gp2_out(i_gp2_out),
    .i_gp17_out(i_gp17_out),
    .i_gp37_out(i_gp37_out),
    .i_gp36_out(i_gp36_out),
    .o_gp0_in(o_gp0_in),
    .o_gp2_in(o_gp2_in),
    .i_low_byte_port(i_low_byte_port),
    .o_low_byte_port(o_low_byte_port),
    .o_low_byte_port_oe(o_low_byte_port_oe),
    .i_high_byte_port(i_high_byte_port),
    .o_high_byte_port(o_high_byte_port),
    .o_high_byte_port_oe(o_high_byte_port_oe),
    .o_address_bit_seventeen(o_address_bit_seventeen),
    .o_address_bit_sixteen(o_address_bit_sixteen),
    .o_write_strobe_n(o_write_strobe_n),
    .o_ale(o_ale),
    .o_program_store_strobe_n(o_program_store_strobe_n)
  );
  emb_mem mem (.i_clock(i_clock), .i_ale(o_ale), .i_pg(!i_first_config_byte[emb_pkg::PAGE_POS]),
    .i_rd(!o_program_store_strobe_n || (i_first_config_byte[2] && !o_address_bit_sixteen)),
    .i_lo(o_low_byte_port), .i_lo_oe(o_low_byte_port_oe), .i_hi(o_high_byte_port),
    .i_hi_oe(o_high_byte_port_oe), .o_lo(i_low_byte_port), .o_hi(i_high_byte_port));
  initial begin
    i_clock = 0;
    forever #5 i_clock = ~i_clock;
  end
  task complete_run;
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %h %h", $time, got, exp);
    end
  endtask : chk
  // Strap must settle through the synchroniser before release
  task rst(input logic ea);
    i_external_access_select = ea;
    i_reset_n = 0;
    repeat (20) @(negedge i_clock);
    i_reset_n = 1;
    repeat (2) @(negedge i_clock);
  endtask : rst
  // One bus cycle; the memory answers with the latched low address xor 5a
  task op(input logic c, input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    int s;
    {i_req, i_req_code, i_req_write, i_req_addr, i_req_wdata} = {1'b1, c, w, a, d};
    @(negedge i_clock);
    i_req = 0;
    n = 0;
    s = 0;
    while (o_done !== 1'b1 && n < 12) begin
      @(negedge i_clock);
      n++;
      // Written byte must stand on its data port while the write strobe is low
      if (o_write_strobe_n === 1'b0) begin
        s++;
        chk(i_first_config_byte[emb_pkg::PAGE_POS] ? o_low_byte_port : o_high_byte_port, d);
      end
    end
    if (n == 12) begin
      failures++;
      complete_run();
    end
    chk(s[7:0], w ? {5'h0, emb_pkg::DATA_CYCLES} : 8'h00);
    if (!w) chk(o_rdata, a[7:0] ^ 8'h5a);
  endtask : op
  initial begin
    {i_req, i_req_code, i_req_write, i_req_addr, i_req_wdata} = '0;
    {i_gp17_out, i_gp37_out, i_gp36_out, i_gp2_out, i_gp0_out} = 19'h7ffff;
    i_onchip_top = emb_pkg::ONCHIP_TOP_RESET;
    i_first_config_byte = emb_pkg::CFG_RESET;
    failures = 0;
    samples_checked = 0;
    rst(1);
    {i_req, i_req_code, i_req_addr} = {2'h3, 18'h00100};
    @(negedge i_clock);
    chk({7'h0, o_onchip}, 8'h01);
    op(0, 0, 18'h01234, 0);
    op(0, 1, 18'h0abcd, 8'h3c);
    op(1, 0, 18'h3c0a5, 0);
    i_first_config_byte = 8'h00;
    op(0, 1, 18'h2a5c3, 8'hc6);
    op(1, 0, 18'h3ffff, 0);
    i_first_config_byte = 8'h03;
    i_gp17_out = 0;
    op(0, 0, 18'h15a96, 0);
    chk({7'h0, o_address_bit_seventeen}, 8'h00);
    i_gp0_out = 8'h0f;
    rst(0);
    chk(o_low_byte_port_oe, 8'hf0);
    chk(o_low_byte_port, 8'h00);
    chk({o_gp0_in[7:4], 4'h0}, 8'h00);
    chk(o_gp2_in, 8'hff);
    i_external_access_select = 1;
    op(1, 0, 18'h00100, 0);
    complete_run();
  end
endmodule : external_memory_bus_pins_test
`default_nettype wire
